// *** logic/pmac_top.sv ***
/*
 * Acquisition mode control for the power monitor converter: mode,
 * status and shunt channel configuration registers, the measurement
 * sequencer and per-channel averaging.
 * Assumes the serial management engine presents decoded register
 * accesses on the same clock, and that the converter front end offers
 * a settled sample on adc_data_in when the sample strobe fires.
 */
`timescale 1ns/1ps
`include "pmac_map.svh"

// Function
// - Power-down bit set stops the converter
// - Idle bit holds converter without acquiring
// - After trigger, idle or power down
// - Mode type bit picks triggered or continuous
// - Mode write starts one triggered cycle
// - Selector maps codes to measured inputs
// - Mode register resets to continuous, selector 010
// - Ready low while converting, high when done
// - Ready flag only operates in triggered mode
// - Mode write clears ready flag
// - Overflow flag set on out-of-range math
// - Conversion time codes 64us to 2.048ms
// - Shunt times in bits 9:7 and 2:0
// - Store only the average of samples
// - Average count two to the code, max 4096
// - Shunt averages in bits 13:10 and 6:3
module pmac_top
  import pmac_pkg::*;
#(
  parameter int unsigned CONV_BASE_CYC = `PMAC_CONV_BASE_CYC
) (
  // Clock and reset
  input  wire logic            core_clk_in,
  input  wire logic            arst_n_in,
  // Register port from the serial management engine
  input  pmac_pkg::pmac_req_s  reg_req_in,
  output pmac_pkg::pmac_rsp_s  reg_rsp_out,
  // Converter front end
  input  wire logic [15:0]     adc_data_in,
  input  wire logic            math_overflow_in,
  output logic                 converter_power_down_out,
  output logic                 converter_idle_out,
  output pmac_pkg::pmac_ch_e   adc_channel_out,
  output logic                 adc_sample_out,
  // Results
  output pmac_pkg::pmac_res_s  results_out,
  output logic                 results_valid_out
);

  import pmac_pkg::*;

  // ******************************************************************
  // Decoding helpers
  // ******************************************************************

  // One bit per input, in the order of pmac_ch_e
  function automatic logic [4:0] sel_to_mask(input logic [2:0] sel);
    logic [4:0] m;
    m = 5'h00;
    unique case (sel)
      3'h0: m = 5'h01;
      3'h1: m = 5'h02;
      3'h2: m = 5'h03;
      3'h3: m = 5'h04;
      3'h4: m = 5'h08;
      3'h5: m = 5'h0C;
      3'h6: m = 5'h10;
      3'h7: m = 5'h1F;
    endcase
    return m;
  endfunction : sel_to_mask

  // Codes 11xx saturate at 4096 samples
  function automatic logic [3:0] avg_shift(input logic [3:0] code);
    return (code[3:2] == 2'b11) ? `PMAC_AVG_MAX_SHIFT : code;
  endfunction : avg_shift

  // ******************************************************************
  // Register storage
  // ******************************************************************
  logic [7:0]  mode_r;
  logic [15:0] ichan_r;
  logic        ready_r;
  logic        ovf_r;
  logic        post_pd_r;
  logic        trig_pend_r;
  logic        mode_wr;
  logic        ichan_wr;
  logic        hit;

  // Byte and word accesses arrive already framed and checked
  assign mode_wr  = reg_req_in.wr && (reg_req_in.addr == `PMAC_OFS_MODE);
  assign ichan_wr = reg_req_in.wr && (reg_req_in.addr == `PMAC_OFS_ICHAN);
  assign hit      = (reg_req_in.addr == `PMAC_OFS_MODE)
                 || (reg_req_in.addr == `PMAC_OFS_STATUS)
                 || (reg_req_in.addr == `PMAC_OFS_ICHAN);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_r <= `PMAC_MODE_RESET;
    end else if (mode_wr) begin
      mode_r <= reg_req_in.wdata[7:0] & `PMAC_MODE_MASK;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ichan_r <= `PMAC_ICH_RESET;
    end else if (ichan_wr) begin
      ichan_r <= reg_req_in.wdata & `PMAC_ICH_MASK;
    end
  end

  // ******************************************************************
  // Mode fields
  // ******************************************************************
  logic       pd_bit;
  logic       idle_bit;
  logic       post_bit;
  logic       cont_bit;
  logic [4:0] ch_mask;
  logic       run_ok;

  assign pd_bit   = mode_r[`PMAC_MODE_PD_BIT];
  assign idle_bit = mode_r[`PMAC_MODE_IDLE_BIT];
  assign post_bit = mode_r[`PMAC_MODE_POST_BIT];
  assign cont_bit = mode_r[`PMAC_MODE_CONT_BIT];
  assign ch_mask  = sel_to_mask(mode_r[`PMAC_MODE_SEL_HI:`PMAC_MODE_SEL_LO]);
  assign run_ok   = !pd_bit && !idle_bit && !post_pd_r;

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  pmac_state_e state_r;
  pmac_ch_e    ch_r;
  logic [12:0] cnt_r;
  logic        tmr_start;
  logic        tmr_done;
  logic        tmr_busy;
  logic [2:0]  ct_code;
  logic [3:0]  shift;
  logic        shunt_ch;
  logic        last_sample;
  logic        cycle_end;
  logic        found;
  pmac_ch_e    next_ch;
  logic        tail_r;
  logic [3:0]  store_shift_r;
  logic [15:0] mean;

  // Per-channel time and averaging, each field independent
  always_comb begin
    ct_code  = `PMAC_VOLT_CT_CODE;
    shift    = 4'h0;
    shunt_ch = 1'b0;
    unique case (ch_r)
      PMAC_CH_PRI_SHUNT: begin
        ct_code  = ichan_r[`PMAC_ICH_PRI_CT_HI:`PMAC_ICH_PRI_CT_LO];
        shift    = avg_shift(ichan_r[`PMAC_ICH_PRI_AVG_HI:
                                     `PMAC_ICH_PRI_AVG_LO]);
        shunt_ch = 1'b1;
      end
      PMAC_CH_AUX_SHUNT: begin
        ct_code  = ichan_r[`PMAC_ICH_AUX_CT_HI:`PMAC_ICH_AUX_CT_LO];
        shift    = avg_shift(ichan_r[`PMAC_ICH_AUX_AVG_HI:
                                     `PMAC_ICH_AUX_AVG_LO]);
        shunt_ch = 1'b1;
      end
      default: begin
        ct_code  = `PMAC_VOLT_CT_CODE;
        shift    = 4'h0;
        shunt_ch = 1'b0;
      end
    endcase
  end

  // Next selected input at or after the current one
  always_comb begin
    found   = 1'b0;
    next_ch = PMAC_CH_PRI_SHUNT;
    for (int i = 4; i >= 0; i--) begin
      if (!tail_r && ch_mask[i] && (3'(i) >= ch_r)) begin
        found   = 1'b1;
        next_ch = pmac_ch_e'(3'(i));
      end
    end
  end

  assign last_sample = (cnt_r == ((13'h1 << shift) - 13'h1));
  assign tmr_start   = (state_r == PMAC_ST_PICK) && found && run_ok
                    && !mode_wr;
  assign cycle_end   = (state_r == PMAC_ST_PICK) && !found && run_ok
                    && !mode_wr;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= PMAC_ST_IDLE;
      ch_r    <= PMAC_CH_PRI_SHUNT;
      cnt_r   <= 13'h0;
    end else if (mode_wr) begin
      // A mode write abandons any cycle in flight and re-arms
      state_r <= PMAC_ST_IDLE;
      ch_r    <= PMAC_CH_PRI_SHUNT;
      cnt_r   <= 13'h0;
    end else if (!run_ok) begin
      state_r <= pd_bit || post_pd_r ? PMAC_ST_OFF : PMAC_ST_IDLE;
      ch_r    <= PMAC_CH_PRI_SHUNT;
      cnt_r   <= 13'h0;
    end else begin
      unique case (state_r)
        PMAC_ST_OFF, PMAC_ST_IDLE: begin
          if (cont_bit || trig_pend_r) begin
            state_r <= PMAC_ST_PICK;
            ch_r    <= PMAC_CH_PRI_SHUNT;
          end else begin
            state_r <= PMAC_ST_IDLE;
          end
        end
        PMAC_ST_PICK: begin
          if (found) begin
            ch_r    <= next_ch;
            cnt_r   <= 13'h0;
            state_r <= PMAC_ST_CONV;
          end else if (cont_bit) begin
            ch_r    <= PMAC_CH_PRI_SHUNT;
            state_r <= PMAC_ST_PICK;
          end else begin
            state_r <= PMAC_ST_IDLE;
          end
        end
        PMAC_ST_CONV: begin
          if (tmr_done) begin
            if (!shunt_ch || last_sample) begin
              state_r <= PMAC_ST_PICK;
              ch_r    <= (ch_r == PMAC_CH_TEMP) ? PMAC_CH_TEMP
                       : pmac_ch_e'(ch_r + 3'h1);
            end else begin
              cnt_r <= cnt_r + 13'h1;
            end
          end
        end
      endcase
    end
  end

  // ******************************************************************
  // Conversion timing and averaging
  // ******************************************************************
  logic conv_restart;
  logic done_ch;

  assign conv_restart = (state_r == PMAC_ST_CONV) && tmr_done
                     && shunt_ch && !last_sample && run_ok && !mode_wr;
  assign done_ch      = (state_r == PMAC_ST_CONV) && tmr_done && run_ok
                     && !mode_wr && (!shunt_ch || last_sample);

  // Temperature is the last input; without this the search finds it again
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tail_r <= 1'b0;
    end else if (mode_wr || !run_ok) begin
      tail_r <= 1'b0;
    end else if (done_ch) begin
      tail_r <= (ch_r == PMAC_CH_TEMP);
    end else if ((state_r == PMAC_ST_PICK) && !found) begin
      tail_r <= 1'b0;
    end
  end

  pmac_conv_timer #(
    .BASE_CYC (CONV_BASE_CYC),
    .CNT_W    (18)
  ) u_timer (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .start_in    (tmr_start || conv_restart),
    .abort_in    (mode_wr || !run_ok),
    .code_in     (tmr_start ? (next_ch == PMAC_CH_PRI_SHUNT
                   ? ichan_r[`PMAC_ICH_PRI_CT_HI:`PMAC_ICH_PRI_CT_LO]
                   : next_ch == PMAC_CH_AUX_SHUNT
                   ? ichan_r[`PMAC_ICH_AUX_CT_HI:`PMAC_ICH_AUX_CT_LO]
                   : `PMAC_VOLT_CT_CODE) : ct_code),
    .busy_out    (tmr_busy),
    .done_out    (tmr_done)
  );

  pmac_averager #(
    .DATA_W (16),
    .ACC_W  (28)
  ) u_avg (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .clear_in    (tmr_start),
    .sample_in   (tmr_done && (state_r == PMAC_ST_CONV)),
    .data_in     (adc_data_in),
    .shift_in    (store_shift_r),
    .mean_out    (mean)
  );

  // ******************************************************************
  // Results
  // ******************************************************************
  // The mean is read one cycle after the last sample lands
  logic     store_r;
  pmac_ch_e store_ch_r;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      store_r       <= 1'b0;
      store_ch_r    <= PMAC_CH_PRI_SHUNT;
      store_shift_r <= 4'h0;
    end else begin
      store_r       <= done_ch;
      store_ch_r    <= ch_r;
      store_shift_r <= shift;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      results_out <= '0;
    end else if (store_r) begin
      unique case (store_ch_r)
        PMAC_CH_PRI_SHUNT: results_out.pri_shunt <= mean;
        PMAC_CH_PRI_BUS:   results_out.pri_bus   <= mean;
        PMAC_CH_AUX_SHUNT: results_out.aux_shunt <= mean;
        PMAC_CH_AUX_BUS:   results_out.aux_bus   <= mean;
        PMAC_CH_TEMP:      results_out.temp      <= mean;
        default:           results_out.temp      <= results_out.temp;
      endcase
    end
  end

  // Cycle-end pulse trails the last store so results are in place
  logic end_r;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      end_r             <= 1'b0;
      results_valid_out <= 1'b0;
    end else begin
      end_r             <= cycle_end;
      results_valid_out <= end_r && !mode_wr;
    end
  end

  // ******************************************************************
  // Trigger bookkeeping and status flags
  // ******************************************************************
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trig_pend_r <= 1'b0;
    end else if (mode_wr) begin
      trig_pend_r <= !reg_req_in.wdata[`PMAC_MODE_CONT_BIT];
    end else if ((state_r == PMAC_ST_IDLE) && run_ok) begin
      trig_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      post_pd_r <= 1'b0;
    end else if (mode_wr) begin
      post_pd_r <= 1'b0;
    end else if (end_r && !cont_bit) begin
      post_pd_r <= post_bit;
    end
  end

  // Clearing by a mode write restarts tracking, so it outranks a set
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ready_r <= 1'b0;
    end else if (mode_wr) begin
      ready_r <= 1'b0;
    end else if (end_r && !cont_bit) begin
      ready_r <= 1'b1;
    end
  end

  // A mode write clears stale overflow; a fresh report wins
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ovf_r <= 1'b0;
    end else if (math_overflow_in) begin
      ovf_r <= 1'b1;
    end else if (mode_wr) begin
      ovf_r <= 1'b0;
    end
  end

  // ******************************************************************
  // Register read-back
  // ******************************************************************
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    unique case (reg_req_in.addr)
      `PMAC_OFS_MODE:   rd_mux = {8'h00, mode_r};
      `PMAC_OFS_STATUS: rd_mux = {14'h0000, ready_r, ovf_r};
      `PMAC_OFS_ICHAN:  rd_mux = ichan_r;
      default:          rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rsp_out <= '0;
    end else begin
      reg_rsp_out.ack   <= reg_req_in.wr || reg_req_in.rd;
      reg_rsp_out.err   <= (reg_req_in.wr || reg_req_in.rd) && !hit;
      reg_rsp_out.rdata <= reg_req_in.rd ? rd_mux : 16'h0000;
    end
  end

  // ******************************************************************
  // Converter front end drive
  // ******************************************************************
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      converter_power_down_out <= 1'b0;
      converter_idle_out       <= 1'b0;
    end else begin
      converter_power_down_out <= pd_bit || post_pd_r;
      converter_idle_out       <= !pd_bit && !post_pd_r
                               && (state_r != PMAC_ST_CONV);
    end
  end

  assign adc_channel_out = ch_r;
  assign adc_sample_out  = tmr_done && (state_r == PMAC_ST_CONV);

endmodule : pmac_top

// *** logic/pmac_map.svh ***
/*
 * Register map, field positions, reset values and timing counts for the
 * power monitor acquisition control block.
 * Assumes a 40 MHz core clock; included by bare name wherever needed.
 */
`ifndef PMAC_MAP_SVH
`define PMAC_MAP_SVH

// ********************************************************************
// Register offsets (command codes)
// ********************************************************************
`define PMAC_OFS_MODE        8'hD2
`define PMAC_OFS_STATUS      8'hD3
`define PMAC_OFS_ICHAN       8'hD4

// ********************************************************************
// Acquisition mode fields
// ********************************************************************
`define PMAC_MODE_PD_BIT     6
`define PMAC_MODE_IDLE_BIT   5
`define PMAC_MODE_POST_BIT   4
`define PMAC_MODE_CONT_BIT   3
`define PMAC_MODE_SEL_HI     2
`define PMAC_MODE_SEL_LO     0
`define PMAC_MODE_MASK       8'h7F
`define PMAC_MODE_RESET      8'h0A

// ********************************************************************
// Conversion status fields
// ********************************************************************
`define PMAC_STAT_READY_BIT  1
`define PMAC_STAT_OVF_BIT    0

// ********************************************************************
// Shunt channel configuration fields
// ********************************************************************
`define PMAC_ICH_AUX_AVG_HI  13
`define PMAC_ICH_AUX_AVG_LO  10
`define PMAC_ICH_AUX_CT_HI   9
`define PMAC_ICH_AUX_CT_LO   7
`define PMAC_ICH_PRI_AVG_HI  6
`define PMAC_ICH_PRI_AVG_LO  3
`define PMAC_ICH_PRI_CT_HI   2
`define PMAC_ICH_PRI_CT_LO   0
`define PMAC_ICH_MASK        16'h3FFF
`define PMAC_ICH_RESET       16'h0387

// ********************************************************************
// Timing
// ********************************************************************
`define PMAC_CLK_PERIOD_PS   25000
`define PMAC_CONV_BASE_PS    64000000
`define PMAC_CONV_BASE_CYC   (`PMAC_CONV_BASE_PS / `PMAC_CLK_PERIOD_PS)
`define PMAC_VOLT_CT_CODE    3'h7
`define PMAC_AVG_MAX_SHIFT   4'hC

`endif

// *** logic/pmac_pkg.sv ***
/*
 * Types shared by the acquisition control block and its helpers.
 * Assumes pmac_map.svh supplies the numeric constants.
 */
package pmac_pkg;

  // ******************************************************************
  // Register port carriers
  // ******************************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } pmac_req_s;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } pmac_rsp_s;

  // ******************************************************************
  // Measurement results
  // ******************************************************************
  typedef struct packed {
    logic [15:0] pri_shunt;
    logic [15:0] pri_bus;
    logic [15:0] aux_shunt;
    logic [15:0] aux_bus;
    logic [15:0] temp;
  } pmac_res_s;

  typedef enum logic [2:0] {
    PMAC_CH_PRI_SHUNT,
    PMAC_CH_PRI_BUS,
    PMAC_CH_AUX_SHUNT,
    PMAC_CH_AUX_BUS,
    PMAC_CH_TEMP
  } pmac_ch_e;

  typedef enum logic [2:0] {
    PMAC_ST_OFF,
    PMAC_ST_IDLE,
    PMAC_ST_PICK,
    PMAC_ST_CONV
  } pmac_state_e;

endpackage : pmac_pkg

// *** logic/pmac_conv_timer.sv ***
/*
 * Conversion time counter: one done pulse after the selected time.
 * Assumes start is a one-cycle pulse from the same clock domain.
 */
`timescale 1ns/1ps
`include "pmac_map.svh"

module pmac_conv_timer #(
  parameter int unsigned BASE_CYC = `PMAC_CONV_BASE_CYC,
  parameter int unsigned CNT_W    = 18
) (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  // Control
  input  wire logic       start_in,
  input  wire logic       abort_in,
  input  wire logic [2:0] code_in,
  // Status
  output logic            busy_out,
  output logic            done_out
);

  logic [CNT_W-1:0] cnt_r;
  logic [2:0]       shift;
  logic [CNT_W-1:0] load;

  // Codes 10x and 11x ignore the low bit
  always_comb begin
    if (code_in[2]) begin
      shift = code_in[1] ? 3'h5 : 3'h4;
    end else begin
      shift = {1'b0, code_in[1:0]};
    end
    load = CNT_W'(BASE_CYC) << shift;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r <= '0;
    end else if (abort_in) begin
      cnt_r <= '0;
    end else if (start_in) begin
      cnt_r <= load;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= !abort_in && (cnt_r == CNT_W'(1));
    end
  end

  assign busy_out = (cnt_r != '0);

endmodule : pmac_conv_timer

// *** logic/pmac_averager.sv ***
/*
 * Sample accumulator that yields the mean of 2**shift samples.
 * Assumes samples are signed and arrive as one-cycle strobes.
 */
`timescale 1ns/1ps

module pmac_averager #(
  parameter int unsigned DATA_W = 16,
  parameter int unsigned ACC_W  = 28
) (
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              arst_n_in,
  // Sample stream
  input  wire logic              clear_in,
  input  wire logic              sample_in,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic [3:0]        shift_in,
  // Running sum shifted right by shift_in
  output logic [DATA_W-1:0]      mean_out
);

  logic signed [ACC_W-1:0] acc_r;
  logic signed [ACC_W-1:0] acc_nxt;
  logic signed [ACC_W-1:0] scaled;

  // Only the mean leaves the block, never the raw samples
  always_comb begin
    acc_nxt = acc_r + ACC_W'($signed(data_in));
    scaled  = acc_r >>> shift_in;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_r <= '0;
    end else if (clear_in) begin
      acc_r <= '0;
    end else if (sample_in) begin
      acc_r <= acc_nxt;
    end
  end

  assign mean_out = scaled[DATA_W-1:0];

endmodule : pmac_averager

// *** tb/pmac_props.sv ***
/* Port checker for pmac_top.
   Assumes it is bound to pmac_top and sees only its ports. */
`timescale 1ns/1ps
module pmac_props
  import pmac_pkg::*;
#(parameter int unsigned CONV_BASE_CYC = 4) (
  // Clock and reset
  input wire logic           core_clk_in,
  input wire logic           arst_n_in,
  // Register port
  input pmac_pkg::pmac_req_s reg_req_in,
  input pmac_pkg::pmac_rsp_s reg_rsp_out,
  // Front end and results
  input wire logic [15:0]    adc_data_in,
  input wire logic           math_overflow_in,
  input wire logic           converter_power_down_out,
  input wire logic           converter_idle_out,
  input pmac_pkg::pmac_ch_e  adc_channel_out,
  input wire logic           adc_sample_out,
  input pmac_pkg::pmac_res_s results_out,
  input wire logic           results_valid_out
);
  logic req;
  logic hit;
  assign req = reg_req_in.wr | reg_req_in.rd;
  assign hit = reg_req_in.addr inside {8'hD2, 8'hD3, 8'hD4};
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  a_ack_after_req: assert property (req |=> reg_rsp_out.ack)
    else $error("ack missing");
  a_ack_has_cause: assert property (reg_rsp_out.ack |-> $past(req))
    else $error("ack without request");
  a_err_on_unmapped: assert property (req && !hit |=> reg_rsp_out.err)
    else $error("err missing");
  a_no_err_mapped: assert property (req && hit |=> !reg_rsp_out.err)
    else $error("err on mapped");
  a_rdata_idle_zero: assert property (
    !reg_rsp_out.ack |-> reg_rsp_out.rdata == 16'h0000)
    else $error("rdata without ack");
  a_status_top_zero: assert property (
    reg_req_in.rd && reg_req_in.addr == 8'hD3
    |=> reg_rsp_out.rdata[15:2] == 14'h0000) else $error("status bits");
  a_mode_top_zero: assert property (
    reg_req_in.rd && reg_req_in.addr == 8'hD2
    |=> reg_rsp_out.rdata[15:7] == 9'h000) else $error("mode bits");
  a_pd_no_sample: assert property (
    converter_power_down_out && $past(converter_power_down_out)
    |-> !adc_sample_out) else $error("sample in power down");
  a_idle_no_sample: assert property (
    converter_idle_out && $past(converter_idle_out)
    |-> !adc_sample_out) else $error("sample in idle");
  a_valid_one_cycle: assert property (
    results_valid_out |=> !results_valid_out) else $error("valid too long");
endmodule : pmac_props

// *** tb/pmac_frontend_model.sv ***
/* Converter front end: a fixed value per channel on each sample strobe.
   Assumes the strobe and channel come from pmac_top on the same clock. */
`timescale 1ns/1ps
module pmac_frontend_model
  import pmac_pkg::*;
(
  // Strobe from the block
  input wire logic          sample_in,
  input pmac_pkg::pmac_ch_e channel_in,
  input wire logic          ovf_req_in,
  // Converter data and math status
  output logic [15:0]       data_out,
  output logic              math_overflow_out
);
  logic [15:0] val;
  assign val = 16'h1000 + 16'(channel_in) * 16'h0111;
  // Outside the strobe the data is not held, so show its inverse
  assign data_out = sample_in ? val : ~val;
  assign math_overflow_out = ovf_req_in;
endmodule : pmac_frontend_model

// *** tb/pmac_top_bench.sv ***
/* Self-checking bench for pmac_top.
   Assumes a shortened conversion base of 4 cycles. */
`timescale 1ns/1ps
module pmac_top_bench;
  import pmac_pkg::*;
  logic clk, arst_n_in, ovf_req, smp, vld, pd, idle, ovf;
  pmac_req_s req;
  pmac_rsp_s rsp;
  pmac_ch_e ch;
  pmac_res_s res;
  logic [15:0] adc, v, got;
  logic [7:0] seen;
  int fail_count, checks_done, n, t, first;
  pmac_top #(.CONV_BASE_CYC(4)) u_dut (.core_clk_in(clk),
    .arst_n_in(arst_n_in), .reg_req_in(req), .reg_rsp_out(rsp),
    .adc_data_in(adc), .math_overflow_in(ovf),
    .converter_power_down_out(pd), .converter_idle_out(idle),
    .adc_channel_out(ch), .adc_sample_out(smp), .results_out(res),
    .results_valid_out(vld));
  pmac_frontend_model u_fe (.sample_in(smp), .channel_in(ch),
    .ovf_req_in(ovf_req), .data_out(adc), .math_overflow_out(ovf));
  function automatic logic [15:0] fe(input int k);
    return 16'h1000 + 16'(k) * 16'h0111;
  endfunction : fe
  function automatic logic [7:0] sel_mask(input int s);
    logic [7:0] m [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C,
                          8'h10, 8'h1F};
    return m[s];
  endfunction : sel_mask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    got = rsp.rdata;
    chk("ack", 16'h1, {15'h0, rsp.ack});
    chk("err", {15'h0, !(a inside {8'hD2, 8'hD3, 8'hD4})}, {15'h0, rsp.err});
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
    acc(1'b0, a, 16'h0000);
    chk(nm, e, got);
  endtask : rd
  task automatic run_seq(input int lim);
    seen = '0; n = 0; first = -1;
    @(negedge clk);
    for (t = 0; t < lim && !vld; t++) begin
      @(negedge clk);
      if (smp && n == 0) first = t;
      if (smp) begin seen[ch] = 1'b1; n++; end
    end
    if (!vld) begin
      $display("mismatch valid exp 1 got 0");
      fail_count++;
      give_verdict();
    end
  endtask : run_seq
  task automatic quiet(input logic [15:0] m);
    acc(1'b1, 8'hD2, m);
    n = 0;
    repeat (300) begin @(negedge clk); n += smp; end
    chk("samples", 16'h0, 16'(n));
  endtask : quiet
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    arst_n_in = 1'b0; req = '0; ovf_req = 1'b0;
    fail_count = 0; checks_done = 0;
    void'($urandom(87950));
    repeat (6) @(negedge clk);
    arst_n_in = 1'b1;
    rd(8'hD2, 16'h000A, "mode");
    rd(8'hD4, 16'h0387, "ichan");
    rd(8'hD7, 16'h0000, "unmapped");
    acc(1'b1, 8'hD2, 16'hFFFF); rd(8'hD2, 16'h007F, "mode");
    acc(1'b1, 8'hD4, 16'hFFFF); rd(8'hD4, 16'h3FFF, "ichan");
    for (int i = 0; i < 6; i++) begin
      v = 16'($urandom) & 16'h3FFF;
      acc(1'b1, 8'hD4, v); rd(8'hD4, v, "ichan");
    end
    for (int c = 0; c < 8; c++) begin
      v = 16'd4 << (c[2] ? (c[1] ? 5 : 4) : c);
      acc(1'b1, 8'hD4, {13'h0, 3'(c)}); acc(1'b1, 8'hD2, 16'h0000);
      run_seq(2000);
      chk("time", 16'h1, {15'h0, first >= v && first <= v + 6});
      chk("pri", fe(0), res.pri_shunt);
    end
    foreach (v[i]) if (i == 2 || i == 13) begin
      acc(1'b1, 8'hD4, 16'(i) << 3); acc(1'b1, 8'hD2, 16'h0000);
      run_seq(40000);
      chk("count", i > 11 ? 16'd4096 : 16'd4, 16'(n));
      chk("mean", fe(0), res.pri_shunt);
    end
    acc(1'b1, 8'hD4, 16'h0000);
    for (int s = 0; s < 8; s++) begin
      acc(1'b1, 8'hD2, 16'(s)); rd(8'hD3, 16'h0000, "status");
      run_seq(2000);
      chk("inputs", {8'h0, sel_mask(s)}, {8'h0, seen});
      rd(8'hD3, 16'h0002, "status");
    end
    for (int k = 0; k < 5; k++) chk("res", fe(k), res[79-16*k -: 16]);
    chk("idle", 16'h1, {15'h0, idle});
    acc(1'b1, 8'hD2, 16'h0010); run_seq(2000);
    repeat (2) @(negedge clk);
    chk("pd", 16'h1, {15'h0, pd});
    quiet(16'h0040); chk("pd", 16'h1, {15'h0, pd});
    quiet(16'h0020); chk("idle", 16'h1, {15'h0, idle});
    ovf_req = 1'b1; @(negedge clk); ovf_req = 1'b0;
    rd(8'hD3, 16'h0001, "status");
    acc(1'b1, 8'hD2, 16'h000A);
    run_seq(2000); run_seq(2000);
    chk("cont", 16'h0003, {8'h0, seen});
    give_verdict();
  end
endmodule : pmac_top_bench
bind pmac_top pmac_props #(.CONV_BASE_CYC(CONV_BASE_CYC)) u_props (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
  .reg_req_in(reg_req_in), .reg_rsp_out(reg_rsp_out),
  .adc_data_in(adc_data_in), .math_overflow_in(math_overflow_in),
  .converter_power_down_out(converter_power_down_out),
  .converter_idle_out(converter_idle_out),
  .adc_channel_out(adc_channel_out), .adc_sample_out(adc_sample_out),
  .results_out(results_out), .results_valid_out(results_valid_out));
